// ---- src/prc_consts.vh ----
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH

// Clock and millisecond tick.
`define PRC_CLK_MHZ        20
`define PRC_TICK_US        1000

// Pairing request input timing, in milliseconds, and the pulse count of the reset sequence.
`define PRC_DEB_MS         12'd20
`define PRC_SHORT_MIN_MS   12'd100
`define PRC_SHORT_MAX_MS   12'd2000
`define PRC_RST_HOLD_MS    12'd3000
`define PRC_RST_PULSES     3'd4

// Durations of pairing states and of the search transmit and receive slots, in milliseconds.
`define PRC_SEARCH_MS      15'd30000
`define PRC_FOUND_MS       15'd3000
`define PRC_FULL_MS        15'd10000
`define PRC_SLOT_MS        15'd50

// Pair list.
`define PRC_LIST_DEPTH     40
`define PRC_LIST_MAX       6'd40
`define PRC_FULL_MASK      8'hff

// Register offsets.
`define PRC_REG_CTRL       8'h00
`define PRC_REG_IOMASK     8'h04
`define PRC_REG_ANALOG     8'h08
`define PRC_REG_LADDR      8'h0c
`define PRC_REG_PERM       8'h10
`define PRC_REG_STATUS     8'h14

// Control register fields.
`define PRC_CTRL_SERIAL    0
`define PRC_CTRL_PAIR      1
`define PRC_CTRL_CANCEL    2

// Reset values.
`define PRC_CTRL_RST       1'b0
`define PRC_IOMASK_RST     8'h00
`define PRC_ANALOG_RST     4'h0
`define PRC_LADDR_RST      32'h00000001

`endif

// ---- src/prc_ctrl.v ----
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "prc_consts.vh"

module prc_ctrl #(
    parameter MS_CYCLES = `PRC_CLK_MHZ * `PRC_TICK_US
) (
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst,
    // Register port.
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Pins.
    input  wire        pair_request,
    input  wire        low_group_direction,
    input  wire        high_group_direction,
    input  wire [7:0]  status_line_in,
    output reg  [7:0]  status_line_out,
    output reg  [7:0]  status_line_oe,
    output reg         state_indicator,
    output reg         tx_amp_enable,
    output reg         rx_amp_enable,
    // Radio core.
    input  wire        radio_tx_mode,
    input  wire        radio_rx_mode,
    input  wire        rx_pkt_valid,
    input  wire [31:0] rx_pkt_src,
    input  wire [7:0]  rx_pkt_lines,
    input  wire        peer_found,
    input  wire [31:0] peer_addr,
    input  wire        peer_table_full,
    output reg         search_active,
    output reg         search_tx,
    output reg         pair_accept,
    output reg         rx_respond,
    output reg  [31:0] local_addr
);

    localparam [2:0] ST_IDLE    = 3'd0;
    localparam [2:0] ST_SEARCH  = 3'd1;
    localparam [2:0] ST_FOUND   = 3'd2;
    localparam [2:0] ST_FULL    = 3'd3;
    localparam [2:0] ST_RFULL   = 3'd4;
    localparam [2:0] ST_CANCEL  = 3'd5;
    localparam [2:0] ST_RSTACK  = 3'd6;
    localparam [2:0] ST_XCANCEL = 3'd7;

    reg  [2:0]  st_ff;
    reg  [2:0]  nxt_st;
    reg  [14:0] ms_cnt_ff;
    reg         tick_ff;
    reg  [10:0] s1_ff, s2_ff, s3_ff, filt_ff;
    reg  [11:0] deb_ms_ff;
    reg         deb_ff;
    reg         deb_d_ff;
    reg  [11:0] hi_ms_ff, lo_ms_ff;
    reg  [2:0]  pulses_ff;
    reg  [14:0] st_ms_ff;
    reg  [11:0] pat_ms_ff;
    reg  [2:0]  pat_step_ff;
    reg         sustain_ff;
    reg         serial_ff;
    reg  [7:0]  iomask_ff;
    reg  [3:0]  analog_ff;
    reg  [5:0]  count_ff;
    reg  [31:0] pl_addr [0:`PRC_LIST_DEPTH-1];
    reg  [7:0]  pl_mask [0:`PRC_LIST_DEPTH-1];
    reg         rx_hit, pr_hit;
    reg  [5:0]  rx_idx, pr_idx;
    reg  [7:0]  dir_in;
    integer     i;
    integer     ln;

    wire pair_rise = deb_ff & ~deb_d_ff;
    wire pair_fall = ~deb_ff & deb_d_ff;
    wire cmd_pair   = reg_wr & (reg_addr == `PRC_REG_CTRL) & reg_wdata[`PRC_CTRL_PAIR];
    wire cmd_cancel = reg_wr & (reg_addr == `PRC_REG_CTRL) & reg_wdata[`PRC_CTRL_CANCEL];
    wire rst_seq    = deb_ff & (pulses_ff == `PRC_RST_PULSES) & (hi_ms_ff > `PRC_RST_HOLD_MS);
    wire store_peer = (st_ff == ST_SEARCH) & peer_found & ~peer_table_full;

    ////////////////////////////////////////////////////////////////////////////////
    // Blink pattern table: phase length in ms, even phases high, zero ends the cycle.

    function [11:0] phase_ms;
        input [2:0] st;
        input [2:0] step;
        begin
            phase_ms = 12'd0;
            case (st)
                ST_SEARCH: phase_ms = (step == 3'd0) ? 12'd100 : (step == 3'd1) ? 12'd900 : 12'd0;
                ST_FOUND:  phase_ms = (step == 3'd0) ? 12'd400 : (step == 3'd1) ? 12'd100 : 12'd0;
                ST_FULL:   phase_ms = (step < 3'd2) ? 12'd100 : 12'd0;
                ST_RFULL:  phase_ms = (step < 3'd3) ? 12'd100 : (step == 3'd3) ? 12'd300 : 12'd0;
                ST_CANCEL: phase_ms = (step == 3'd1) ? 12'd200 : (step < 3'd3) ? 12'd100 : 12'd0;
                ST_RSTACK: begin
                    case (step)
                        3'd0:    phase_ms = 12'd600;
                        3'd2:    phase_ms = 12'd200;
                        3'd4:    phase_ms = 12'd200;
                        3'd1:    phase_ms = 12'd100;
                        3'd3:    phase_ms = 12'd100;
                        3'd5:    phase_ms = 12'd100;
                        default: phase_ms = 12'd0;
                    endcase
                end
                default:   phase_ms = 12'd0;
            endcase
        end
    endfunction

    wire [11:0] cur_phase  = phase_ms(st_ff, pat_step_ff);
    wire [11:0] next_phase = phase_ms(st_ff, pat_step_ff + 3'd1);

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and input synchronisers.

    always @(posedge mclk) begin
        if (rst) begin
            ms_cnt_ff <= 15'd0;
            tick_ff   <= 1'b0;
        end else if (ms_cnt_ff == MS_CYCLES[14:0] - 15'd1) begin
            ms_cnt_ff <= 15'd0;
            tick_ff   <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 15'd1;
            tick_ff   <= 1'b0;
        end
    end

    // A bit only moves once the second and third stages agree, which rejects a single metastable sample.
    always @(posedge mclk) begin
        if (rst) begin
            s1_ff   <= 11'h000;
            s2_ff   <= 11'h000;
            s3_ff   <= 11'h000;
            filt_ff <= 11'h000;
        end else begin
            s1_ff   <= {pair_request, high_group_direction, low_group_direction, status_line_in};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
        end
    end

    // The debounce window is far shorter than the 100 ms least pulse, so it never eats a valid pulse.
    always @(posedge mclk) begin
        if (rst) begin
            deb_ms_ff <= 12'd0;
            deb_ff    <= 1'b0;
            deb_d_ff  <= 1'b0;
        end else begin
            deb_d_ff <= deb_ff;
            if (filt_ff[10] == deb_ff) begin
                deb_ms_ff <= 12'd0;
            end else if (tick_ff) begin
                if (deb_ms_ff >= `PRC_DEB_MS - 12'd1) begin
                    deb_ff    <= filt_ff[10];
                    deb_ms_ff <= 12'd0;
                end else begin
                    deb_ms_ff <= deb_ms_ff + 12'd1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse width measurement for the factory reset sequence.

    always @(posedge mclk) begin
        if (rst) begin
            hi_ms_ff  <= 12'd0;
            lo_ms_ff  <= 12'd0;
            pulses_ff <= 3'd0;
        end else begin
            if (pair_rise) begin
                hi_ms_ff <= 12'd0;
                if (lo_ms_ff < `PRC_SHORT_MIN_MS || lo_ms_ff > `PRC_SHORT_MAX_MS) begin
                    pulses_ff <= 3'd0;
                end
            end else if (pair_fall) begin
                lo_ms_ff <= 12'd0;
                if (hi_ms_ff >= `PRC_SHORT_MIN_MS && hi_ms_ff <= `PRC_SHORT_MAX_MS &&
                    pulses_ff < `PRC_RST_PULSES) begin
                    pulses_ff <= pulses_ff + 3'd1;
                end else begin
                    pulses_ff <= 3'd0;
                end
            end else if (tick_ff) begin
                if (deb_ff && hi_ms_ff != 12'hfff) begin
                    hi_ms_ff <= hi_ms_ff + 12'd1;
                end
                if (!deb_ff && lo_ms_ff != 12'hfff) begin
                    lo_ms_ff <= lo_ms_ff + 12'd1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pair list lookup.

    always @* begin
        rx_hit = 1'b0;
        pr_hit = 1'b0;
        rx_idx = 6'd0;
        pr_idx = 6'd0;
        for (i = 0; i < `PRC_LIST_DEPTH; i = i + 1) begin
            if (i < count_ff && pl_addr[i] == rx_pkt_src && !rx_hit) begin
                rx_hit = 1'b1;
                rx_idx = i[5:0];
            end
            if (i < count_ff && pl_addr[i] == peer_addr && !pr_hit) begin
                pr_hit = 1'b1;
                pr_idx = i[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pairing state machine.

    always @* begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (pair_rise || cmd_pair) begin
                    nxt_st = (count_ff == `PRC_LIST_MAX) ? ST_FULL : ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (pair_rise || cmd_cancel) begin
                    nxt_st = ST_CANCEL;
                end else if (peer_found) begin
                    nxt_st = peer_table_full ? ST_RFULL : ST_FOUND;
                end else if (!deb_ff && (sustain_ff || st_ms_ff >= `PRC_SEARCH_MS)) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_FOUND: begin
                if (!deb_ff && st_ms_ff >= `PRC_FOUND_MS) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_FULL, ST_RFULL: begin
                if (st_ms_ff >= `PRC_FULL_MS) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_CANCEL: begin
                if (pair_rise) begin
                    nxt_st = ST_SEARCH;
                end else if (deb_ff && hi_ms_ff > `PRC_SHORT_MAX_MS) begin
                    nxt_st = ST_XCANCEL;
                end else if (!deb_ff && pat_step_ff == 3'd3) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_RSTACK: begin
                if (!deb_ff) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_XCANCEL: begin
                if (!deb_ff) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
        // The hold that completes the reset sequence wins over whatever pairing step it started.
        if (rst_seq && st_ff != ST_RSTACK) begin
            nxt_st = ST_RSTACK;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            st_ff       <= ST_IDLE;
            st_ms_ff    <= 15'd0;
            pat_ms_ff   <= 12'd0;
            pat_step_ff <= 3'd0;
            sustain_ff  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (nxt_st != st_ff) begin
                st_ms_ff    <= 15'd0;
                pat_ms_ff   <= 12'd0;
                pat_step_ff <= 3'd0;
                sustain_ff  <= 1'b0;
            end else begin
                if (deb_ff && hi_ms_ff > `PRC_SHORT_MAX_MS) begin
                    sustain_ff <= 1'b1;
                end
                if (tick_ff) begin
                    if (st_ms_ff != 15'h7fff) begin
                        st_ms_ff <= st_ms_ff + 15'd1;
                    end
                    if (cur_phase != 12'd0) begin
                        if (pat_ms_ff + 12'd1 >= cur_phase) begin
                            pat_ms_ff <= 12'd0;
                            // Cancel is a one-shot and parks on its trailing low phase.
                            if (next_phase != 12'd0 || st_ff == ST_CANCEL) begin
                                pat_step_ff <= pat_step_ff + 3'd1;
                            end else begin
                                pat_step_ff <= 3'd0;
                            end
                        end else begin
                            pat_ms_ff <= pat_ms_ff + 12'd1;
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers, pair list storage and line control.

    always @(posedge mclk) begin
        if (store_peer) begin
            pl_addr[pr_hit ? pr_idx : count_ff] <= peer_addr;
            pl_mask[pr_hit ? pr_idx : count_ff] <= `PRC_FULL_MASK;
        end else if (reg_wr && reg_addr == `PRC_REG_PERM && reg_wdata[13:8] < count_ff) begin
            pl_mask[reg_wdata[13:8]] <= reg_wdata[7:0];
        end
    end

    always @* begin
        for (ln = 0; ln < 8; ln = ln + 1) begin
            dir_in[ln] = serial_ff ? iomask_ff[ln] : filt_ff[8 + ln / 4];
        end
        dir_in[7:4] = dir_in[7:4] | analog_ff;
    end

    always @(posedge mclk) begin
        if (rst) begin
            serial_ff  <= `PRC_CTRL_RST;
            iomask_ff  <= `PRC_IOMASK_RST;
            analog_ff  <= `PRC_ANALOG_RST;
            local_addr <= `PRC_LADDR_RST;
            count_ff   <= 6'd0;
            reg_rdata  <= 32'h00000000;
        end else begin
            if (st_ff == ST_RSTACK && nxt_st == ST_IDLE) begin
                serial_ff <= `PRC_CTRL_RST;
                iomask_ff <= `PRC_IOMASK_RST;
                analog_ff <= `PRC_ANALOG_RST;
                count_ff  <= 6'd0;
            end else begin
                if (store_peer && !pr_hit) begin
                    count_ff <= count_ff + 6'd1;
                end
                if (reg_wr) begin
                    case (reg_addr)
                        `PRC_REG_CTRL:   serial_ff  <= reg_wdata[`PRC_CTRL_SERIAL];
                        `PRC_REG_IOMASK: iomask_ff  <= reg_wdata[7:0];
                        `PRC_REG_LADDR:  local_addr <= reg_wdata;
                        `PRC_REG_ANALOG: begin
                            // A selection of three or four lines is refused whole.
                            if (!((reg_wdata[0] & reg_wdata[1] & (reg_wdata[2] | reg_wdata[3])) |
                                  (reg_wdata[2] & reg_wdata[3] & (reg_wdata[0] | reg_wdata[1])))) begin
                                analog_ff <= reg_wdata[3:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `PRC_REG_CTRL:   reg_rdata <= {31'h00000000, serial_ff};
                    `PRC_REG_IOMASK: reg_rdata <= {24'h000000, iomask_ff};
                    `PRC_REG_ANALOG: reg_rdata <= {28'h0000000, analog_ff};
                    `PRC_REG_LADDR:  reg_rdata <= local_addr;
                    `PRC_REG_STATUS: reg_rdata <= {16'h0000, 2'b00, count_ff, 1'b0, pulses_ff, deb_ff, st_ff};
                    default:         reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            status_line_out <= 8'h00;
            status_line_oe  <= 8'h00;
            state_indicator <= 1'b0;
            tx_amp_enable   <= 1'b0;
            rx_amp_enable   <= 1'b0;
            search_active   <= 1'b0;
            search_tx       <= 1'b0;
            pair_accept     <= 1'b0;
            rx_respond      <= 1'b0;
        end else begin
            status_line_oe <= ~dir_in;
            rx_respond     <= rx_pkt_valid & rx_hit;
            if (rx_pkt_valid && rx_hit) begin
                status_line_out <= (status_line_out & ~(pl_mask[rx_idx] & ~dir_in)) |
                                   (rx_pkt_lines & pl_mask[rx_idx] & ~dir_in);
            end
            pair_accept   <= store_peer;
            search_active <= (nxt_st == ST_SEARCH);
            if (nxt_st != ST_SEARCH) begin
                search_tx <= 1'b0;
            end else if (tick_ff && st_ms_ff % `PRC_SLOT_MS == 15'd0) begin
                search_tx <= ~search_tx;
            end
            tx_amp_enable <= radio_tx_mode | (search_active & search_tx);
            rx_amp_enable <= radio_rx_mode | (search_active & ~search_tx);
            case (st_ff)
                ST_IDLE:    state_indicator <= radio_tx_mode | radio_rx_mode;
                ST_XCANCEL: state_indicator <= 1'b1;
                default:    state_indicator <= ~pat_step_ff[0] & (cur_phase != 12'd0);
            endcase
        end
    end

endmodule

// ---- tb/prc_ctrl_test.sv ----
`timescale 1ns/1ps
`include "prc_consts.vh"
module prc_ctrl_test;
    localparam MS = 4;
    localparam [31:0] PEER = 32'h5a3c0f96;
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         pair_request = 1'b0;
    reg         lo_dir = 1'b0;
    reg         hi_dir = 1'b0;
    reg  [7:0]  pins = 8'h00;
    reg         tx_mode = 1'b0;
    reg         rx_mode = 1'b0;
    reg         peer_searching = 1'b0;
    wire [31:0] reg_rdata, local_addr, pkt_src, p_addr;
    wire [7:0]  line_out, line_oe, pkt_lines;
    wire        led, tx_amp, rx_amp, pkt_valid, p_found, p_full, s_act, s_tx, accept, respond;
    integer     fail_count = 0, cmp_count = 0, cycles = 0, i, j, n, k;
    reg  [31:0] d, lad, exp_out, lines;
    reg  [31:0] pair_q[$];
    reg  [7:0]  perm_m;

    prc_ctrl #(.MS_CYCLES(MS)) prc_ctrl_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pair_request(pair_request), .low_group_direction(lo_dir), .high_group_direction(hi_dir),
        .status_line_in(pins), .status_line_out(line_out), .status_line_oe(line_oe),
        .state_indicator(led), .tx_amp_enable(tx_amp), .rx_amp_enable(rx_amp),
        .radio_tx_mode(tx_mode), .radio_rx_mode(rx_mode), .rx_pkt_valid(pkt_valid),
        .rx_pkt_src(pkt_src), .rx_pkt_lines(pkt_lines), .peer_found(p_found), .peer_addr(p_addr),
        .peer_table_full(p_full), .search_active(s_act), .search_tx(s_tx), .pair_accept(accept),
        .rx_respond(respond), .local_addr(local_addr));
    prc_peer #(.ADDR(PEER)) prc_peer_inst (.mclk(mclk), .peer_searching(peer_searching),
        .peer_full(j == 2), .search_active(s_act), .search_tx(s_tx), .rx_pkt_valid(pkt_valid),
        .rx_pkt_src(pkt_src), .rx_pkt_lines(pkt_lines), .peer_found(p_found), .peer_addr(p_addr),
        .peer_table_full(p_full));

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 90000) begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Sampling 1 ns after the edge keeps the bench clear of the design's updates.
    task hold(input integer c);
        repeat (c) begin @(posedge mclk); #1; end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
            hold(1);
            reg_wr <= 1'b0;
            hold(1);
        end
    endtask
    task rd(input [7:0] a);
        begin
            reg_addr <= a; reg_rd <= 1'b1;
            hold(1);
            reg_rd <= 1'b0;
            d = reg_rdata;
            hold(1);
        end
    endtask
    task wait_state(input [2:0] s);
        begin
            n = 0;
            rd(`PRC_REG_STATUS);
            while (d[2:0] !== s && n < 3000) begin hold(20); rd(`PRC_REG_STATUS); n = n + 1; end
            check(d[2:0], s);
        end
    endtask
    // Returns the length of the next complete high phase of the indicator.
    task meas_high;
        begin
            k = 0;
            while (led === 1'b1 && k < 9000) begin hold(1); k = k + 1; end
            while (led !== 1'b1 && k < 9000) begin hold(1); k = k + 1; end
            k = 0;
            while (led === 1'b1 && k < 9000) begin hold(1); k = k + 1; end
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i = $urandom(96);
        hold(10);
        rst <= 1'b0;
        hold(1);
        check(local_addr, `PRC_LADDR_RST);
        rd(8'h20);
        check(d, 32'h0);
        lad = $urandom;
        wr(`PRC_REG_LADDR, lad);
        rd(`PRC_REG_LADDR);
        check(d, lad);
        $display("test 1 done");
        for (i = 0; i < 4; i = i + 1) begin
            lo_dir <= i[0]; hi_dir <= i[1]; pins <= $urandom; tx_mode <= $urandom; rx_mode <= $urandom;
            hold(12);
            check(line_oe, {{4{~i[1]}}, {4{~i[0]}}});
            check(tx_amp, tx_mode);
            check(rx_amp, rx_mode);
            check(led, tx_mode | rx_mode);
        end
        lo_dir <= 1'b0; hi_dir <= 1'b0; tx_mode <= 1'b0; rx_mode <= 1'b0;
        lines = $urandom;
        wr(`PRC_REG_CTRL, 32'h1);
        wr(`PRC_REG_IOMASK, {24'h0, lines[7:0]});
        hold(3);
        check(line_oe, {24'h0, ~lines[7:0]});
        for (i = 0; i < 2; i = i + 1) begin
            wr(`PRC_REG_ANALOG, i ? 32'h7 : 32'h5); // Three analog lines must be refused.
            hold(3);
            check(line_oe, {24'h0, ~lines[7:0] & 8'haf});
        end
        wr(`PRC_REG_ANALOG, 32'h0);
        wr(`PRC_REG_CTRL, 32'h0);
        $display("test 2 done");
        wr(`PRC_REG_CTRL, 32'h2);
        wait_state(3'd1);
        meas_high;
        check(k >= 99 * MS && k <= 101 * MS, 1);
        wr(`PRC_REG_CTRL, 32'h4);
        wait_state(3'd5);
        meas_high;
        check(k >= 99 * MS && k <= 101 * MS, 1);
        wait_state(3'd0);
        $display("test 3 done");
        for (j = 0; j < 2; j = j + 1) begin
            peer_searching <= 1'b1;
            wr(`PRC_REG_CTRL, 32'h2);
            n = 0;
            while (accept !== 1'b1 && n < 4000) begin hold(1); n = n + 1; end
            peer_searching <= 1'b0;
            check(accept, 1);
            n = 0;
            foreach (pair_q[m]) if (pair_q[m] == PEER) n = 1;
            if (n == 0) pair_q.push_back(PEER);
            rd(`PRC_REG_STATUS);
            check(d[13:8], pair_q.size());
            check(d[2:0], 3'd2);
            meas_high;
            check(k >= 399 * MS && k <= 401 * MS, 1);
            wait_state(3'd0);
        end
        $display("test 4 done");
        exp_out = 0;
        perm_m = `PRC_FULL_MASK;
        for (i = 0; i < 6; i = i + 1) begin
            lines = $urandom;
            if (i == 2) begin
                perm_m = $urandom;
                wr(`PRC_REG_PERM, {24'h0, perm_m});
            end
            prc_peer_inst.send_pkt(i == 4 ? ~PEER : PEER, lines[7:0]);
            if (i != 4) exp_out = (lines & perm_m) | (exp_out & ~perm_m);
            check(respond, i != 4);
            check(line_out, exp_out[7:0]);
        end
        $display("test 5 done");
        for (i = 0; i < 4; i = i + 1) begin
            pair_request <= 1'b1;
            hold(500 * MS);
            pair_request <= 1'b0;
            hold(500 * MS);
        end
        pair_request <= 1'b1;
        hold(3500 * MS);
        wait_state(3'd6);
        meas_high;
        check(k >= 199 * MS && k <= 201 * MS, 1);
        pair_request <= 1'b0;
        wait_state(3'd0);
        pair_q.delete();
        check(d[13:8], pair_q.size());
        rd(`PRC_REG_IOMASK);
        check(d, `PRC_IOMASK_RST);
        check(local_addr, lad);
        peer_searching <= 1'b1;
        wr(`PRC_REG_CTRL, 32'h2);
        wait_state(3'd4);
        $display("test 6 done");
        tally_and_finish;
    end
endmodule

// ---- tb/prc_peer.sv ----
`timescale 1ns/1ps
module prc_peer #(
    parameter [31:0] ADDR = 32'h5a3c0f96
) (
    // Clock and control from the bench.
    input  wire        mclk,
    input  wire        peer_searching,
    input  wire        peer_full,
    // Device side.
    input  wire        search_active,
    input  wire        search_tx,
    output reg         rx_pkt_valid = 1'b0,
    output reg  [31:0] rx_pkt_src = 32'h0,
    output reg  [7:0]  rx_pkt_lines = 8'h00,
    output reg         peer_found = 1'b0,
    output reg  [31:0] peer_addr = 32'h0,
    output reg         peer_table_full = 1'b0
);
    reg heard = 1'b0;
    // A released bus toggles so a stale value never looks valid.
    always @(posedge mclk) begin
        peer_found <= 1'b0;
        peer_addr <= ~peer_addr;
        peer_table_full <= ~peer_table_full;
        if (!search_active || !peer_searching)
            heard <= 1'b0;
        else if (search_tx)
            heard <= 1'b1;
        else if (heard) begin
            peer_found <= 1'b1;
            peer_addr <= ADDR;
            peer_table_full <= peer_full;
            heard <= 1'b0;
        end
    end
    task send_pkt(input [31:0] src, input [7:0] lines);
        begin
            @(posedge mclk);
            #1;
            rx_pkt_valid <= 1'b1;
            rx_pkt_src <= src;
            rx_pkt_lines <= lines;
            @(posedge mclk);
            #1;
            rx_pkt_valid <= 1'b0;
            rx_pkt_src <= ~src;
            rx_pkt_lines <= ~lines;
        end
    endtask
endmodule

// ---- tb/prc_sva.sv ----
`timescale 1ns/1ps
module prc_sva (
    // Watched ports.
    input wire       mclk,
    input wire       rst,
    input wire       radio_tx_mode,
    input wire       radio_rx_mode,
    input wire       tx_amp_enable,
    input wire       rx_amp_enable,
    input wire       rx_pkt_valid,
    input wire       peer_found,
    input wire       peer_table_full,
    input wire       search_active,
    input wire       search_tx,
    input wire       pair_accept,
    input wire       rx_respond,
    input wire [7:0] status_line_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_tx_amp: assert property ($rose(radio_tx_mode) |-> ##[1:2] tx_amp_enable)
        else $error("transmit amp enable late");
    a_rx_amp: assert property ($rose(radio_rx_mode) |-> ##[1:2] rx_amp_enable)
        else $error("receive amp enable late");
    a_accept_cause: assert property (pair_accept |-> $past(peer_found && search_active && !peer_table_full))
        else $error("peer stored without a search contact");
    a_accept_pulse: assert property (pair_accept |=> !pair_accept)
        else $error("store pulse longer than one cycle");
    a_found_ends: assert property (pair_accept |=> !search_active)
        else $error("search still running after pairing");
    a_slot_search: assert property (search_tx |-> search_active)
        else $error("transmit slot outside search");
    a_respond_cause: assert property (rx_respond |-> $past(rx_pkt_valid))
        else $error("response without a packet");
    a_lines_hold: assert property (!rx_respond |-> $stable(status_line_out))
        else $error("status lines moved without an accepted packet");
    c_pair: cover property (pair_accept);
    c_resp: cover property (rx_respond);
    c_search: cover property ($rose(search_active));
endmodule

bind prc_ctrl prc_sva prc_sva_inst (.mclk(mclk), .rst(rst), .radio_tx_mode(radio_tx_mode),
    .radio_rx_mode(radio_rx_mode), .tx_amp_enable(tx_amp_enable), .rx_amp_enable(rx_amp_enable),
    .rx_pkt_valid(rx_pkt_valid), .peer_found(peer_found), .peer_table_full(peer_table_full),
    .search_active(search_active), .search_tx(search_tx), .pair_accept(pair_accept),
    .rx_respond(rx_respond), .status_line_out(status_line_out));
